/* hdl/ep0_handshake.sv */
// picks the handshake for each host token from stall and nak state
module ep0_handshake (
	ep0_link_if.decide lk
);
	// stall outranks nak; an oversize OUT gets nothing at all
	assign lk.in_hs = !lk.in_req ? ep0_pkg::HS_NONE :
		lk.in_stall ? ep0_pkg::HS_STALL :
		lk.in_nak ? ep0_pkg::HS_NAK : ep0_pkg::HS_ACK;
	assign lk.out_hs = !lk.out_req ? ep0_pkg::HS_NONE :
		lk.out_too_long ? ep0_pkg::HS_NONE :
		lk.out_stall ? ep0_pkg::HS_STALL :
		lk.out_nak ? ep0_pkg::HS_NAK : ep0_pkg::HS_ACK;
endmodule // ep0_handshake

/* hdl/ep0_link_if.sv */
// events between the register block and the handshake decider
interface ep0_link_if;
	logic in_req;
	logic out_req;
	logic out_too_long;
	logic in_stall;
	logic out_stall;
	logic in_nak;
	logic out_nak;
	ep0_pkg::handshake_t in_hs;
	ep0_pkg::handshake_t out_hs;
	modport regs (output in_req, out_req, out_too_long, in_stall, out_stall, in_nak, out_nak,
		input in_hs, out_hs);
	modport decide (input in_req, out_req, out_too_long, in_stall, out_stall, in_nak, out_nak,
		output in_hs, out_hs);
endinterface

/* hdl/ep0_pkg.sv */
// constants shared by the endpoint-0 descriptor register block
// What this block does
// - four endpoint-0 registers at fixed local addresses in external data space.
// - no base address register; buffer starts come only from the size field.
// - two-bit size field, reset zero, picks 8, 16, 32 or 64 bytes.
// - out buffer starts at e000; in buffer starts at e000 plus size.
// - completion interrupt enable bit 2 per direction gates completion interrupts.
// - in stall bit 3 answers IN with STALL; cleared by next SETUP.
// - out stall bit 3 answers OUT with STALL; cleared by hardware afterwards.
// - toggle bit 5 read-only, hardware kept, reset on every SETUP.
// - nak interrupt enable bit 6 per direction raises interrupt on each NAK sent.
// - data mover enable bit 7 per direction grants the bridge mover the endpoint.
// - in byte count limited to 0..64; writes above 0x40 store 0x40.
// - in nak resets to one and NAKs IN until firmware clears it.
// - out nak zero accepts OUT data; one holds packet and NAKs OUT.
// - OUT packet above 64 bytes is dropped silently, count unchanged, no handshake.
package ep0_pkg;
	// ============================================================
	// register addresses
	localparam logic [15:0] ADDR_IN_CONFIG = 16'hf000;
	localparam logic [15:0] ADDR_IN_COUNT = 16'hf001;
	localparam logic [15:0] ADDR_OUT_CONFIG = 16'hf003;
	localparam logic [15:0] ADDR_OUT_COUNT = 16'hf004;
	// ============================================================
	// field positions
	localparam int SIZE_LSB = 0;
	localparam int COMPL_IE_BIT = 2;
	localparam int STALL_BIT = 3;
	localparam int TOGGLE_BIT = 5;
	localparam int NAK_IE_BIT = 6;
	localparam int MOVER_EN_BIT = 7;
	localparam int NAK_BIT = 7;
	// ============================================================
	// reset values and limits
	localparam logic [7:0] IN_CONFIG_RESET = 8'h00;
	localparam logic [7:0] OUT_CONFIG_RESET = 8'h00;
	localparam logic [7:0] IN_COUNT_RESET = 8'h80;
	localparam logic [7:0] OUT_COUNT_RESET = 8'h00;
	localparam logic [6:0] MAX_COUNT = 7'h40;
	localparam logic [15:0] BUFFER_BASE = 16'he000;
	localparam logic [7:0] SIZE_8 = 8'h08;
	// ============================================================
	// handshake answers
	typedef enum logic [1:0] {HS_NONE, HS_ACK, HS_NAK, HS_STALL} handshake_t;
	// ============================================================
	// buffer size from the size field: 8 << code
	function automatic logic [7:0] size_bytes(input logic [1:0] code);
		size_bytes = SIZE_8 << code;
	endfunction
endpackage

/* hdl/ep0_regs.sv */
// endpoint-0 descriptor registers and handshake control
module ep0_regs (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [15:0] xaddr,
	input wire logic xwr,
	input wire logic xrd,
	input wire logic [7:0] xwdata,
	output logic [7:0] xrdata,
	input wire logic setup_rx,
	input wire logic in_token,
	input wire logic in_acked,
	input wire logic out_token,
	input wire logic [7:0] out_len,
	output logic [1:0] in_handshake,
	output logic [1:0] out_handshake,
	output logic [15:0] in_buffer_start,
	output logic [15:0] out_buffer_start,
	output logic [6:0] in_count,
	output logic in_data_toggle,
	output logic out_data_toggle,
	output logic in_mover_ok,
	output logic out_mover_ok,
	output logic in_irq,
	output logic out_irq
);
	// ============================================================
	// storage
	logic [7:0] in_cfg_q, in_cfg_d, out_cfg_q, out_cfg_d;
	logic [7:0] in_cnt_q, in_cnt_d, out_cnt_q, out_cnt_d;
	logic in_wait_q, in_wait_d;
	ep0_link_if lk ();
	ep0_handshake u_hs (.lk(lk));
	// ============================================================
	// address decode
	wire wr_in_cfg = xwr && xaddr == ep0_pkg::ADDR_IN_CONFIG;
	wire wr_in_cnt = xwr && xaddr == ep0_pkg::ADDR_IN_COUNT;
	wire wr_out_cfg = xwr && xaddr == ep0_pkg::ADDR_OUT_CONFIG;
	wire wr_out_cnt = xwr && xaddr == ep0_pkg::ADDR_OUT_COUNT;
	wire [1:0] size_code = in_cfg_q[1:0];
	wire [7:0] size_b = ep0_pkg::size_bytes(size_code);
	wire too_long = out_len > {1'b0, ep0_pkg::MAX_COUNT};
	// ============================================================
	// link towards the handshake decider
	assign lk.in_req = in_token;
	assign lk.out_req = out_token;
	assign lk.out_too_long = too_long;
	assign lk.in_stall = in_cfg_q[ep0_pkg::STALL_BIT];
	assign lk.out_stall = out_cfg_q[ep0_pkg::STALL_BIT];
	assign lk.in_nak = in_cnt_q[ep0_pkg::NAK_BIT];
	assign lk.out_nak = out_cnt_q[ep0_pkg::NAK_BIT];
	wire in_ack = lk.in_hs == ep0_pkg::HS_ACK;
	wire out_ack = lk.out_hs == ep0_pkg::HS_ACK;
	wire in_nak_sent = lk.in_hs == ep0_pkg::HS_NAK;
	wire out_nak_sent = lk.out_hs == ep0_pkg::HS_NAK;
	wire out_stall_sent = lk.out_hs == ep0_pkg::HS_STALL;
	wire in_done = in_wait_q && in_acked;
	wire [6:0] wr_count = (xwdata[6:0] > ep0_pkg::MAX_COUNT) ? ep0_pkg::MAX_COUNT :
		xwdata[6:0];
	// ============================================================
	// next-state logic
	always_comb begin
		in_cfg_d = in_cfg_q;
		out_cfg_d = out_cfg_q;
		in_cnt_d = in_cnt_q;
		out_cnt_d = out_cnt_q;
		in_wait_d = in_wait_q;
		if (wr_in_cfg) begin
			// toggle and reserved stay under hardware control
			in_cfg_d = {xwdata[7:6], in_cfg_q[5:4], xwdata[3:0]};
		end
		if (wr_out_cfg) begin
			out_cfg_d = {xwdata[7:6], out_cfg_q[5:4], xwdata[3:2], 2'b00};
		end
		if (wr_in_cnt) begin
			in_cnt_d = {xwdata[7], wr_count};
		end
		if (wr_out_cnt) begin
			// count is read-only to firmware
			out_cnt_d = {xwdata[7], out_cnt_q[6:0]};
		end
		if (in_ack) begin
			in_wait_d = 1'b1;
		end
		if (in_done) begin
			// buffer returns to firmware on the same edge as the completion interrupt
			in_wait_d = 1'b0;
			in_cnt_d[ep0_pkg::NAK_BIT] = 1'b1;
			in_cfg_d[ep0_pkg::TOGGLE_BIT] = ~in_cfg_q[ep0_pkg::TOGGLE_BIT];
		end
		if (out_ack) begin
			out_cnt_d = {1'b1, out_len[6:0]};
			out_cfg_d[ep0_pkg::TOGGLE_BIT] = ~out_cfg_q[ep0_pkg::TOGGLE_BIT];
		end
		if (out_stall_sent) begin
			out_cfg_d[ep0_pkg::STALL_BIT] = 1'b0;
		end
		if (setup_rx) begin
			in_cfg_d[ep0_pkg::STALL_BIT] = 1'b0;
			in_cfg_d[ep0_pkg::TOGGLE_BIT] = 1'b0;
			out_cfg_d[ep0_pkg::TOGGLE_BIT] = 1'b0;
			in_wait_d = 1'b0;
		end
	end
	// ============================================================
	// register read mux
	logic [7:0] rd_d;
	always_comb begin
		case (xaddr)
			ep0_pkg::ADDR_IN_CONFIG: rd_d = in_cfg_q;
			ep0_pkg::ADDR_IN_COUNT: rd_d = in_cnt_q;
			ep0_pkg::ADDR_OUT_CONFIG: rd_d = out_cfg_q;
			ep0_pkg::ADDR_OUT_COUNT: rd_d = out_cnt_q;
			default: rd_d = 8'h00;
		endcase
	end
	// ============================================================
	// flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			in_cfg_q <= ep0_pkg::IN_CONFIG_RESET;
			out_cfg_q <= ep0_pkg::OUT_CONFIG_RESET;
			in_cnt_q <= ep0_pkg::IN_COUNT_RESET;
			out_cnt_q <= ep0_pkg::OUT_COUNT_RESET;
			in_wait_q <= 1'b0;
		end else begin
			in_cfg_q <= in_cfg_d;
			out_cfg_q <= out_cfg_d;
			in_cnt_q <= in_cnt_d;
			out_cnt_q <= out_cnt_d;
			in_wait_q <= in_wait_d;
		end
	end
	// outputs, all registered
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			xrdata <= 8'h00;
			in_handshake <= 2'b00;
			out_handshake <= 2'b00;
			in_buffer_start <= ep0_pkg::BUFFER_BASE;
			out_buffer_start <= ep0_pkg::BUFFER_BASE;
			in_count <= 7'h00;
			in_data_toggle <= 1'b0;
			out_data_toggle <= 1'b0;
			in_mover_ok <= 1'b0;
			out_mover_ok <= 1'b0;
			in_irq <= 1'b0;
			out_irq <= 1'b0;
		end else begin
			xrdata <= xrd ? rd_d : 8'h00;
			in_handshake <= lk.in_hs;
			out_handshake <= lk.out_hs;
			// hardwired placement, no base register
			in_buffer_start <= ep0_pkg::BUFFER_BASE + {8'h00, size_b};
			out_buffer_start <= ep0_pkg::BUFFER_BASE;
			in_count <= in_cnt_q[6:0];
			in_data_toggle <= in_cfg_q[ep0_pkg::TOGGLE_BIT];
			out_data_toggle <= out_cfg_q[ep0_pkg::TOGGLE_BIT];
			in_mover_ok <= in_cfg_q[ep0_pkg::MOVER_EN_BIT];
			out_mover_ok <= out_cfg_q[ep0_pkg::MOVER_EN_BIT];
			in_irq <= (in_done && in_cfg_q[ep0_pkg::COMPL_IE_BIT]) ||
				(in_nak_sent && in_cfg_q[ep0_pkg::NAK_IE_BIT]);
			out_irq <= (out_ack && out_cfg_q[ep0_pkg::COMPL_IE_BIT]) ||
				(out_nak_sent && out_cfg_q[ep0_pkg::NAK_IE_BIT]);
		end
	end
endmodule // ep0_regs

/* verif/ep0_host_model.sv */
// behavioural usb host issuing endpoint-0 traffic
module ep0_host_model (
	input wire logic clk,
	input wire logic [1:0] in_handshake,
	output logic setup_rx = 1'b0,
	output logic in_token = 1'b0,
	output logic in_acked = 1'b0,
	output logic out_token = 1'b0,
	output logic [7:0] out_len = 8'h00
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// host transactions
	task setup();
		@(posedge clk) setup_rx <= 1'b1;
		@(posedge clk) setup_rx <= 1'b0;
	endtask
	// data taken only when answered with ack; a nak means retry later
	task in_tx();
		@(posedge clk) in_token <= 1'b1;
		@(posedge clk) in_token <= 1'b0;
		@(posedge clk) in_acked <= (in_handshake == 2'h1);
		@(posedge clk) in_acked <= 1'b0;
	endtask
	task out_tx(input logic [7:0] n);
		@(posedge clk) out_len <= n;
		out_token <= 1'b1;
		// length is not held once the token is gone
		@(posedge clk) out_len <= ~n;
		out_token <= 1'b0;
		@(posedge clk);
	endtask
endmodule // ep0_host_model

/* verif/ep0_regs_monitor.sv */
// assertion checker for the endpoint-0 register block
module ep0_regs_monitor (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [15:0] xaddr,
	input wire logic xwr,
	input wire logic [7:0] xwdata,
	input wire logic setup_rx,
	input wire logic in_token,
	input wire logic in_acked,
	input wire logic out_token,
	input wire logic [7:0] out_len,
	input wire logic [1:0] in_handshake,
	input wire logic [1:0] out_handshake,
	input wire logic [15:0] in_buffer_start,
	input wire logic [6:0] in_count,
	input wire logic in_data_toggle,
	input wire logic in_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// port checks
	logic [7:0] w_q;
	always_ff @(posedge clk) if (xwr) w_q <= xwdata;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_cnt; xwr && xaddr == 16'hf001 |->
		##[1:2] in_count == (w_q[6:0] > 7'h40 ? 7'h40 : w_q[6:0]); endproperty
	a_cnt: assert property (p_cnt) else $error("count not clamped");
	property p_start; xwr && xaddr == 16'hf000 |->
		##[1:2] in_buffer_start == 16'he000 + (16'h8 << w_q[1:0]); endproperty
	a_start: assert property (p_start) else $error("in start wrong");
	property p_in_hs; in_handshake != 2'h0 |-> $past(in_token); endproperty
	a_in_hs: assert property (p_in_hs) else $error("stray in answer");
	property p_out_hs; out_handshake != 2'h0 |-> $past(out_token); endproperty
	a_out_hs: assert property (p_out_hs) else $error("stray out answer");
	property p_long; out_token && out_len > 8'h40 |=> out_handshake == 2'h0; endproperty
	a_long: assert property (p_long) else $error("long packet answered");
	property p_tog; setup_rx |-> ##[1:2] !in_data_toggle; endproperty
	a_tog: assert property (p_tog) else $error("toggle kept");
	property p_stall; setup_rx ##[1:2] in_token |=> in_handshake != 2'h3; endproperty
	a_stall: assert property (p_stall) else $error("stall kept");
	property p_irq; in_irq |-> $past(in_token, 2) || $past(in_token) || $past(in_acked); endproperty
	a_irq: assert property (p_irq) else $error("irq without cause");
	c_stall: cover property (in_handshake == 2'h3);
	c_ack: cover property (out_handshake == 2'h1);
	c_irq: cover property (in_irq);
endmodule // ep0_regs_monitor

bind ep0_regs ep0_regs_monitor i_mon (
	.clk(clk),
	.rst_n(rst_n),
	.xaddr(xaddr),
	.xwr(xwr),
	.xwdata(xwdata),
	.setup_rx(setup_rx),
	.in_token(in_token),
	.in_acked(in_acked),
	.out_token(out_token),
	.out_len(out_len),
	.in_handshake(in_handshake),
	.out_handshake(out_handshake),
	.in_buffer_start(in_buffer_start),
	.in_count(in_count),
	.in_data_toggle(in_data_toggle),
	.in_irq(in_irq)
);

/* verif/usb_endpoint0_descriptor_regs_tb.sv */
// self-checking bench for the endpoint-0 register block
module usb_endpoint0_descriptor_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst_n = 1'b0, xwr = 1'b0, xrd = 1'b0, rd_d = 1'b0;
	logic [15:0] xaddr = 16'h0000, in_buffer_start, out_buffer_start;
	logic [7:0] xwdata = 8'h00, xrdata, out_len, v;
	logic setup_rx, in_token, in_acked, out_token, in_data_toggle, out_data_toggle;
	logic in_mover_ok, out_mover_ok, in_irq, out_irq;
	logic [1:0] in_handshake, out_handshake;
	logic [6:0] in_count;
	int n_errors = 0, check_count = 0, n_irq = 0, n_oirq = 0, cyc = 0;
	logic [7:0] q_rd[$];
	logic [3:0] q_hs[$];
	ep0_regs i_dut (
		.clk(clk),
		.rst_n(rst_n),
		.xaddr(xaddr),
		.xwr(xwr),
		.xrd(xrd),
		.xwdata(xwdata),
		.xrdata(xrdata),
		.setup_rx(setup_rx),
		.in_token(in_token),
		.in_acked(in_acked),
		.out_token(out_token),
		.out_len(out_len),
		.in_handshake(in_handshake),
		.out_handshake(out_handshake),
		.in_buffer_start(in_buffer_start),
		.out_buffer_start(out_buffer_start),
		.in_count(in_count),
		.in_data_toggle(in_data_toggle),
		.out_data_toggle(out_data_toggle),
		.in_mover_ok(in_mover_ok),
		.out_mover_ok(out_mover_ok),
		.in_irq(in_irq),
		.out_irq(out_irq)
	);
	ep0_host_model i_host (
		.clk(clk),
		.in_handshake(in_handshake),
		.setup_rx(setup_rx),
		.in_token(in_token),
		.in_acked(in_acked),
		.out_token(out_token),
		.out_len(out_len)
	);
	initial forever #2 clk = ~clk;
	// ==========
	// helpers
	task check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task give_verdict();
		// an expected answer that never showed up is a mismatch too
		if (q_rd.size() != 0 || q_hs.size() != 0) n_errors++;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk) xaddr <= a;
		xwdata <= d;
		xwr <= 1'b1;
		@(posedge clk) xwr <= 1'b0;
	endtask
	task rd(input logic [15:0] a, input logic [7:0] e);
		q_rd.push_back(e);
		@(posedge clk) xaddr <= a;
		xrd <= 1'b1;
		@(posedge clk) xrd <= 1'b0;
		@(posedge clk);
	endtask
	task tin(input logic [1:0] e);
		q_hs.push_back({e, 2'h0});
		i_host.in_tx();
	endtask
	task tout(input logic [7:0] n, input logic [1:0] e);
		if (e != 2'h0) q_hs.push_back({2'h0, e});
		i_host.out_tx(n);
	endtask
	always @(posedge clk) begin
		rd_d <= xrd;
		cyc <= cyc + 1;
		if (in_irq === 1'b1) n_irq <= n_irq + 1;
		if (out_irq === 1'b1) n_oirq <= n_oirq + 1;
		if (rd_d) check(xrdata, q_rd.pop_front());
		if (rst_n === 1'b1 && (in_handshake | out_handshake) !== 2'h0)
			check({in_handshake, out_handshake}, q_hs.pop_front());
		if (cyc == 1000) begin
			n_errors++;
			give_verdict();
		end
	end
	// ==========
	// tests
	initial begin
		void'($urandom(61));
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd(16'hf000, 8'h00);
		rd(16'hf001, 8'h80);
		rd(16'hf003, 8'h00);
		rd(16'hf004, 8'h00);
		rd(16'hf002, 8'h00);
		$display("reset test done");
		for (int c = 0; c < 4; c++) begin
			wr(16'hf000, 8'(c));
			// register lands on one edge, the output flop follows on the next
			repeat (2) @(posedge clk);
			check(in_buffer_start, 16'he000 + (16'h8 << c));
			check(out_buffer_start, 16'he000);
		end
		$display("size test done");
		for (int i = 0; i < 6; i++) begin
			v = (i < 2) ? 8'h40 + 8'(i) : 8'($urandom);
			wr(16'hf001, v);
			rd(16'hf001, {v[7], (v[6:0] > 7'h40) ? 7'h40 : v[6:0]});
		end
		$display("count test done");
		wr(16'hf001, 8'h80);
		wr(16'hf000, 8'h44);
		tin(2'h2);
		wr(16'hf001, 8'h05);
		tin(2'h1);
		rd(16'hf001, 8'h85);
		check(in_count, 16'h0005);
		rd(16'hf000, 8'h64);
		check(16'(n_irq), 16'h0002);
		wr(16'hf000, 8'h08);
		tin(2'h3);
		i_host.setup();
		tin(2'h2);
		rd(16'hf000, 8'h00);
		$display("in test done");
		wr(16'hf003, 8'hcc);
		repeat (2) @(posedge clk);
		check({in_mover_ok, out_mover_ok}, 2'b01);
		tout(8'h08, 2'h3);
		tout(8'h08, 2'h1);
		rd(16'hf004, 8'h88);
		tout(8'h08, 2'h2);
		wr(16'hf004, 8'h00);
		tout(8'h41, 2'h0);
		rd(16'hf004, 8'h08);
		rd(16'hf003, 8'he4);
		check(out_data_toggle, 16'h0001);
		check(16'(n_oirq), 16'h0002);
		$display("out test done");
		// let the last queued compare run before the report
		repeat (2) @(posedge clk);
		give_verdict();
	end
endmodule // usb_endpoint0_descriptor_regs_tb
